// >>> hw/pofc_pkg.sv
/*
  Package for the pin ownership, output enable and glitch filter slice.
  Holds register offsets, reset values and filter timing.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
`default_nettype none

package pofc_pkg;

  localparam int          PIN_COUNT        = 32;

  // Register byte offsets
  localparam logic [7:0]  OFS_TAKE_SET     = 8'h00;
  localparam logic [7:0]  OFS_RELEASE_SET  = 8'h04;
  localparam logic [7:0]  OFS_OWNER_STAT   = 8'h08;
  localparam logic [7:0]  OFS_OE_SET       = 8'h10;
  localparam logic [7:0]  OFS_OE_CLEAR     = 8'h14;
  localparam logic [7:0]  OFS_OE_STAT      = 8'h18;
  localparam logic [7:0]  OFS_FILT_SET     = 8'h20;
  localparam logic [7:0]  OFS_FILT_CLEAR   = 8'h24;
  localparam logic [7:0]  OFS_FILT_STAT    = 8'h28;

  // Reset values and the read value of unmapped offsets
  localparam logic [31:0] RST_OWNER        = 32'h01FFFFFF;
  localparam logic [31:0] RST_OE           = 32'h00000000;
  localparam logic [31:0] RST_FILT         = 32'h00000000;
  localparam logic [31:0] RD_UNMAPPED      = 32'h00000000;

  // Filter: level must stand this many clocks before it passes
  localparam int          FILT_STABLE_CYC  = 2;

endpackage : pofc_pkg

`default_nettype wire

// >>> hw/pofc_sync.sv
/*
  Two-flop synchroniser bank for the pin inputs.
  Assumes inputs are asynchronous to CORE_CLK.
*/
`timescale 1ns/10ps
`default_nettype none

module pofc_sync #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } pofc_sync_t;

  pofc_sync_t st_reg;
  pofc_sync_t st_next;

  // First stage feeds only the second
  always_comb begin
    st_next      = st_reg;
    st_next.meta = async_in;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.sync;

endmodule // pofc_sync

`default_nettype wire

// >>> hw/pofc_filter.sv
/*
  Per-pin glitch filter: output follows input only after the input has
  held the new level for a set number of clocks; bypassed when disabled.
  Assumes synchronised inputs.
*/
`timescale 1ns/10ps
`default_nettype none

module pofc_filter #(
  parameter int WIDTH  = 32,
  parameter int STABLE = 2
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] din,
  input  wire logic [WIDTH-1:0] enable,
  output var  logic [WIDTH-1:0] dout
);

  localparam int CW = $clog2(STABLE + 1);

  typedef struct packed {
    logic [WIDTH-1:0]         filt;
    logic [WIDTH-1:0][CW-1:0] cnt;
  } pofc_filt_t;

  pofc_filt_t st_reg;
  pofc_filt_t st_next;

  // Per-pin stability counters; a differing level must persist
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (din[i] == st_reg.filt[i]) begin
        st_next.cnt[i] = '0;
      end else if (st_reg.cnt[i] == CW'(STABLE - 1)) begin
        st_next.filt[i] = din[i];
        st_next.cnt[i]  = '0;
      end else begin
        st_next.cnt[i] = st_reg.cnt[i] + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Bypass when off; filtered copy keeps tracking for a clean switch
  generate
    for (genvar g = 0; g < WIDTH; g++) begin : g_sel
      assign dout[g] = enable[g] ? st_reg.filt[g] : din[g];
    end
  endgenerate

endmodule // pofc_filter

`default_nettype wire

// >>> hw/pofc_top.sv
/*
  Pin ownership, output enable and glitch filter control for 32 lines,
  with a classic Wishbone slave for its registers.
  Assumes pin inputs are asynchronous; peripheral signals run on CORE_CLK.
*/
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module pofc_top #(
  parameter int NPIN = pofc_pkg::PIN_COUNT
) (
  input  wire logic            CORE_CLK,
  input  wire logic            ARST_N,
  // Wishbone slave
  input  wire logic            WB_CYC_I,
  input  wire logic            WB_STB_I,
  input  wire logic            WB_WE_I,
  input  wire logic [7:0]      WB_ADR_I,
  input  wire logic [3:0]      WB_SEL_I,
  input  wire logic [31:0]     WB_DAT_I,
  output var  logic [31:0]     WB_DAT_O,
  output var  logic            WB_ACK_O,
  // Pads
  input  wire logic [NPIN-1:0] PIN_I,
  output var  logic [NPIN-1:0] PIN_O,
  output var  logic [NPIN-1:0] PIN_OE,
  // Peripheral side of each pin
  input  wire logic [NPIN-1:0] PERIPH_O,
  input  wire logic [NPIN-1:0] PERIPH_OE,
  output var  logic [NPIN-1:0] PERIPH_I,
  // Controller side toward output-data and level logic
  input  wire logic [NPIN-1:0] CTRL_DATA_O,
  output var  logic [NPIN-1:0] CTRL_PIN_I,
  output var  logic [NPIN-1:0] OWNER_STATUS,
  output var  logic [NPIN-1:0] OE_STATUS
);

  typedef struct packed {
    logic [NPIN-1:0] owner;
    logic [NPIN-1:0] oe;
    logic [NPIN-1:0] filt;
    logic [NPIN-1:0] pin_o;
    logic [NPIN-1:0] pin_oe;
    logic [NPIN-1:0] periph_i;
    logic [NPIN-1:0] ctrl_i;
    logic [31:0]     dat_o;
    logic            ack;
  } pofc_state_t;

  pofc_state_t     st_reg;
  pofc_state_t     st_next;
  logic [NPIN-1:0] pin_sync;
  logic [NPIN-1:0] pin_clean;
  logic [31:0]     wmask;
  logic            req;
  logic            wr;

  // Pads reach logic only through two flops
  pofc_sync #(
    .WIDTH    (NPIN)
  ) u_sync (
    .clk      (CORE_CLK),
    .arst_n   (ARST_N),
    .async_in (PIN_I),
    .sync_out (pin_sync)
  );

  // One filter per pin, serving both input paths
  pofc_filter #(
    .WIDTH    (NPIN),
    .STABLE   (pofc_pkg::FILT_STABLE_CYC)
  ) u_filt (
    .clk      (CORE_CLK),
    .arst_n   (ARST_N),
    .din      (pin_sync),
    .enable   (st_reg.filt),
    .dout     (pin_clean)
  );

  // Byte lanes widen to a bit mask for partial writes
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = WB_DAT_I[b*8 +: 8] & {8{WB_SEL_I[b]}};
    end
  end

  // New request only while no ack is outstanding
  assign req = WB_CYC_I && WB_STB_I && !st_reg.ack;
  assign wr  = req && WB_WE_I;

  // Register writes, read mux and pin muxing
  always_comb begin
    st_next       = st_reg;
    st_next.ack   = req;
    st_next.dat_o = pofc_pkg::RD_UNMAPPED;
    if (wr) begin
      if (WB_ADR_I == pofc_pkg::OFS_TAKE_SET) begin
        st_next.owner = st_reg.owner | wmask[NPIN-1:0];
      end else if (WB_ADR_I == pofc_pkg::OFS_RELEASE_SET) begin
        st_next.owner = st_reg.owner & ~wmask[NPIN-1:0];
      end else if (WB_ADR_I == pofc_pkg::OFS_OE_SET) begin
        st_next.oe = st_reg.oe | wmask[NPIN-1:0];
      end else if (WB_ADR_I == pofc_pkg::OFS_OE_CLEAR) begin
        st_next.oe = st_reg.oe & ~wmask[NPIN-1:0];
      end else if (WB_ADR_I == pofc_pkg::OFS_FILT_SET) begin
        st_next.filt = st_reg.filt | wmask[NPIN-1:0];
      end else if (WB_ADR_I == pofc_pkg::OFS_FILT_CLEAR) begin
        st_next.filt = st_reg.filt & ~wmask[NPIN-1:0];
      end
    end else if (req) begin
      // Write-only and unmapped offsets read as zero
      if (WB_ADR_I == pofc_pkg::OFS_OWNER_STAT) begin
        st_next.dat_o = 32'(st_reg.owner);
      end else if (WB_ADR_I == pofc_pkg::OFS_OE_STAT) begin
        st_next.dat_o = 32'(st_reg.oe);
      end else if (WB_ADR_I == pofc_pkg::OFS_FILT_STAT) begin
        st_next.dat_o = 32'(st_reg.filt);
      end
    end
    // Pin drive from the updated ownership and enables, so the pad
    // settles in the same cycle as the status registers
    for (int i = 0; i < NPIN; i++) begin
      if (st_next.owner[i]) begin
        st_next.pin_oe[i]   = st_next.oe[i];
        st_next.pin_o[i]    = CTRL_DATA_O[i];
        st_next.periph_i[i] = 1'b0;
      end else begin
        st_next.pin_oe[i]   = PERIPH_OE[i];
        st_next.pin_o[i]    = PERIPH_O[i];
        st_next.periph_i[i] = pin_clean[i];
      end
      st_next.ctrl_i[i] = pin_clean[i];
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg       <= '0;
      st_reg.owner <= pofc_pkg::RST_OWNER[NPIN-1:0];
      st_reg.oe    <= pofc_pkg::RST_OE[NPIN-1:0];
      st_reg.filt  <= pofc_pkg::RST_FILT[NPIN-1:0];
    end else begin
      st_reg <= st_next;
    end
  end

  // All outputs straight from flops
  assign WB_DAT_O     = st_reg.dat_o;
  assign WB_ACK_O     = st_reg.ack;
  assign PIN_O        = st_reg.pin_o;
  assign PIN_OE       = st_reg.pin_oe;
  assign PERIPH_I     = st_reg.periph_i;
  assign CTRL_PIN_I   = st_reg.ctrl_i;
  assign OWNER_STATUS = st_reg.owner;
  assign OE_STATUS    = st_reg.oe;

endmodule // pofc_top

`default_nettype wire

// >>> sim/pofc_monitor.sv
/* Assertions on the pofc_top ports. Assumes byte lanes gated by SEL, as the design does. */
`timescale 1ns/10ps
`default_nettype none
module pofc_monitor #(parameter int NPIN = 32) (
  input wire logic            CORE_CLK,
  input wire logic            ARST_N,
  input wire logic            WB_CYC_I,
  input wire logic            WB_STB_I,
  input wire logic            WB_WE_I,
  input wire logic [7:0]      WB_ADR_I,
  input wire logic [3:0]      WB_SEL_I,
  input wire logic [31:0]     WB_DAT_I,
  input wire logic [31:0]     WB_DAT_O,
  input wire logic            WB_ACK_O,
  input wire logic [NPIN-1:0] PIN_OE,
  input wire logic [NPIN-1:0] PERIPH_OE,
  input wire logic [NPIN-1:0] PERIPH_I,
  input wire logic [NPIN-1:0] OWNER_STATUS,
  input wire logic [NPIN-1:0] OE_STATUS
);
  logic [31:0] lane_data;
  // Unselected byte lanes carry no set or clear bits
  assign lane_data = WB_DAT_I & {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  // Request taken at this edge
  sequence s_wr(logic [7:0] a); WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_ADR_I == a; endsequence
  sequence s_rd(logic [7:0] a); WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O && WB_ADR_I == a; endsequence
  property p_take; s_wr(pofc_pkg::OFS_TAKE_SET) |=> OWNER_STATUS == ($past(OWNER_STATUS) | $past(lane_data)); endproperty
  a_take: assert property (p_take) else $error("take write missed");
  property p_rel; s_wr(pofc_pkg::OFS_RELEASE_SET) |=> OWNER_STATUS == ($past(OWNER_STATUS) & ~$past(lane_data)); endproperty
  a_rel: assert property (p_rel) else $error("release write missed");
  property p_hold; !(WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O) |=> $stable(OWNER_STATUS); endproperty
  a_hold: assert property (p_hold) else $error("owner moved without write");
  property p_oes; s_wr(pofc_pkg::OFS_OE_SET) |=> OE_STATUS == ($past(OE_STATUS) | $past(lane_data)); endproperty
  a_oes: assert property (p_oes) else $error("enable set missed");
  property p_oec; s_wr(pofc_pkg::OFS_OE_CLEAR) |=> OE_STATUS == ($past(OE_STATUS) & ~$past(lane_data)); endproperty
  a_oec: assert property (p_oec) else $error("enable clear missed");
  // Input and ownership are registered from the same next state, so no lag
  property p_pzero; (PERIPH_I & OWNER_STATUS) == '0; endproperty
  a_pzero: assert property (p_pzero) else $error("peripheral input not held low");
  property p_drv; $stable(OWNER_STATUS) && $stable(OE_STATUS) |-> (PIN_OE & OWNER_STATUS) == (OE_STATUS & OWNER_STATUS); endproperty
  a_drv: assert property (p_drv) else $error("owned pad enable wrong");
  property p_pdrv; $past(ARST_N) && $stable(OWNER_STATUS) |-> (PIN_OE & ~OWNER_STATUS) == ($past(PERIPH_OE) & ~OWNER_STATUS); endproperty
  a_pdrv: assert property (p_pdrv) else $error("peripheral pad enable wrong");
  property p_rdo; s_rd(pofc_pkg::OFS_OWNER_STAT) |=> WB_DAT_O == $past(OWNER_STATUS); endproperty
  a_rdo: assert property (p_rdo) else $error("owner read wrong");
  property p_rde; s_rd(pofc_pkg::OFS_OE_STAT) |=> WB_DAT_O == $past(OE_STATUS); endproperty
  a_rde: assert property (p_rde) else $error("enable read wrong");
endmodule // pofc_monitor
bind pofc_top pofc_monitor #(.NPIN(NPIN)) i_mon (.*);
`default_nettype wire

// >>> sim/pofc_pads.sv
/* Pads and peripheral beside pofc_top. Assumes one clock; no pulls on the pads. */
`timescale 1ns/10ps
`default_nettype none
module pofc_pads (
  input  wire logic        clk,
  input  wire logic [31:0] pin_o,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] ext_en,
  input  wire logic [31:0] ext_val,
  output var  logic [31:0] pin_i,
  output var  logic [31:0] per_o,
  output var  logic [31:0] per_oe
);
  logic [31:0] float_reg = 32'h0;
  // Undriven lines flip every cycle so a stale level never passes
  always @(posedge clk) begin
    float_reg <= ~float_reg;
  end
  assign per_o = float_reg; // Peripheral data keeps moving
  assign per_oe = 32'h00000001;
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & float_reg);
endmodule // pofc_pads
`default_nettype wire

// >>> sim/tb.sv
/* Self-checking bench for pofc_top. Assumes the pad model and the bound monitor. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {logic [7:0] a; logic [31:0] d, own, oe, filt;} pofc_row_t;
  logic        clk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0, ack;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, q, pin_i, pin_o, pin_oe, per_o, per_oe, per_i, ctl_i, own, oe, s1, s2;
  logic [31:0] ext_val = 32'h0;
  int          n_errors = 0, comparisons = 0, cycles = 0;
  pofc_row_t   rows [8] = '{'{8'h00, 32'hFE000000, 32'hFFFFFFFF, 32'h0, 32'h0},
    '{8'h04, 32'h0000000F, 32'hFFFFFFF0, 32'h0, 32'h0}, '{8'h10, 32'h000000FF, 32'hFFFFFFF0, 32'hFF, 32'h0},
    '{8'h14, 32'h00000081, 32'hFFFFFFF0, 32'h7E, 32'h0}, '{8'h20, 32'h0000000C, 32'hFFFFFFF0, 32'h7E, 32'hC},
    '{8'h24, 32'h00000004, 32'hFFFFFFF0, 32'h7E, 32'h8}, '{8'h08, 32'hA5A5A5A5, 32'hFFFFFFF0, 32'h7E, 32'h8},
    '{8'h0C, 32'hFFFFFFFF, 32'hFFFFFFF0, 32'h7E, 32'h8}};
  pofc_top i_dut (.CORE_CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PIN_I(pin_i), .PIN_O(pin_o),
    .PIN_OE(pin_oe), .PERIPH_O(per_o), .PERIPH_OE(per_oe), .PERIPH_I(per_i), .CTRL_DATA_O(32'h00000055),
    .CTRL_PIN_I(ctl_i), .OWNER_STATUS(own), .OE_STATUS(oe));
  pofc_pads i_pads (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .ext_en(32'h0000000C), .ext_val(ext_val),
    .pin_i(pin_i), .per_o(per_o), .per_oe(per_oe));
  always #5 clk = ~clk;
  // Hang guard, well above the planned run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // Classic cycle, entered just after a rising edge: hold until ack is
  // sampled high, take data at that edge, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat_i <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 0; stb <= 0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] eo, input logic [31:0] ee, input logic [31:0] ef);
    wb(0, pofc_pkg::OFS_OWNER_STAT, 32'h0); cmp("owner", eo, q);
    wb(0, pofc_pkg::OFS_OE_STAT, 32'h0); cmp("oe", ee, q);
    wb(0, pofc_pkg::OFS_FILT_STAT, 32'h0); cmp("filter", ef, q);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1;
    chk(32'h01FFFFFF, 32'h0, 32'h0);
    foreach (rows[i]) begin
      wb(1, rows[i].a, rows[i].d);
      chk(rows[i].own, rows[i].oe, rows[i].filt);
    end
    wb(0, 8'h0C, 32'h0); cmp("unmapped", 32'h0, q);
    @(negedge clk);
    cmp("pad_oe", 32'h00000070, pin_oe & own);
    cmp("per_in", 32'h0, per_i & own);
    cmp("pad_o", 32'h00000050, pin_o & pin_oe & own);
    cmp("per_pad_oe", 32'h00000001, pin_oe & ~own);
    // One-cycle glitch on peripheral pins 2 and 3, only 3 filtered
    s1 = 0; s2 = 0;
    @(posedge clk) ext_val <= 32'hC;
    @(posedge clk) ext_val <= 32'h0;
    repeat (10) begin @(negedge clk); s1 |= per_i; s2 |= ctl_i; end
    cmp("glitch_per", 32'h4, s1 & 32'hC);
    cmp("glitch_ctl", 32'h4, s2 & 32'hC);
    @(posedge clk) ext_val <= 32'h8;
    repeat (8) @(negedge clk);
    cmp("held_per", 32'h8, per_i & 32'hC);
    // Only byte lane 0 acts: pins 4 and 5 go back, lane 1 bits ignored
    @(posedge clk);
    sel <= 4'h1;
    wb(1, pofc_pkg::OFS_RELEASE_SET, 32'h00000F30);
    sel <= 4'hF;
    chk(32'hFFFFFFC0, 32'h7E, 32'h8);
    @(posedge clk) arst_n <= 0;
    @(posedge clk) arst_n <= 1;
    chk(32'h01FFFFFF, 32'h0, 32'h0);
    end_sim();
  end
endmodule // tb
`default_nettype wire
